// ==== ccpt_pkg.sv ====
// Package of constants and types for the capture/compare/PWM timer
package ccpt_pkg;

  // ----------------------------------------
  // Channel modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CCPT_MODE_OFF,
    CCPT_MODE_CAPTURE,
    CCPT_MODE_COMPARE,
    CCPT_MODE_PWM
  } ccpt_mode_t;

  // ----------------------------------------
  // Count source select
  // ----------------------------------------
  typedef enum logic {
    CCPT_SRC_CLOCK,
    CCPT_SRC_EVENT
  } ccpt_src_t;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int          CCPT_STD_WIDTH  = 16;
  localparam int          CCPT_WIDE_WIDTH = 32;
  localparam int          CCPT_NUM_CH     = 4;
  localparam int          CCPT_DT_WIDTH   = 8;
  localparam logic [31:0] CCPT_CNT_RST    = 32'h0000_0000;
  localparam logic [7:0]  CCPT_DT_RST     = 8'h00;

endpackage : ccpt_pkg

// ==== ccpt_timer.sv ====
// Capture/compare/PWM timer with event count source and event outputs
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Standard instance core is a 16-bit up-counter.
// - Up to four independent channels capture or compare against the counter.
// - Each channel runs in one mode: off, capture, compare or PWM.
// - Capture mode copies the counter into a buffer on the input event.
// - Compare mode output shows the counter versus compare threshold result.
// - PWM waveform follows successive compare values written by software.
// - Dead-time insertion exists only in instance zero of each kind.
// - Wide variant is identical but 32 bits wide.
// - Counter counts clock cycles or external events by selection.
// - Timer emits event pulses onto the event routing network.
module ccpt_timer
  import ccpt_pkg::*;
#(
  parameter int WIDTH    = CCPT_STD_WIDTH,
  parameter int NUM_CH   = CCPT_NUM_CH,
  parameter int INSTANCE = 0
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  input  wire logic                         cnt_enable,
  input  wire ccpt_src_t                    cnt_source,
  input  wire logic                         count_event_in,
  input  wire ccpt_mode_t [NUM_CH-1:0]      ch_mode,
  input  wire logic [NUM_CH-1:0][WIDTH-1:0] ch_compare,
  input  wire logic [NUM_CH-1:0]            ch_capture_in,
  input  wire logic                         dt_enable,
  input  wire logic [CCPT_DT_WIDTH-1:0]     dt_cycles,
  output logic [WIDTH-1:0]                  counter_value,
  output logic [NUM_CH-1:0][WIDTH-1:0]      ch_capture_buf,
  output logic [NUM_CH-1:0]                 ch_out,
  output logic [NUM_CH-1:0]                 ch_out_comp,
  output logic                              overflow_event,
  output logic [NUM_CH-1:0]                 ch_event
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam bit HAS_DT = (INSTANCE == 0);

  typedef struct packed {
    logic                         cnt_sync1;
    logic                         cnt_sync2;
    logic                         cnt_prev;
    logic [NUM_CH-1:0]            cap_sync1;
    logic [NUM_CH-1:0]            cap_sync2;
    logic [NUM_CH-1:0]            cap_prev;
    logic [WIDTH-1:0]             cnt;
    logic [NUM_CH-1:0][WIDTH-1:0] cap_buf;
    logic [NUM_CH-1:0]            raw;
    logic [NUM_CH-1:0]            out_hi;
    logic [NUM_CH-1:0]            out_lo;
    logic [NUM_CH-1:0][CCPT_DT_WIDTH-1:0] dt_cnt;
    logic                         ovf;
    logic [NUM_CH-1:0]            ev;
  } ccpt_state_t;

  ccpt_state_t st_r;
  ccpt_state_t st_nxt;
  logic        tick;
  logic [NUM_CH-1:0] cap_edge;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.cnt_sync1 = count_event_in;
    st_nxt.cnt_sync2 = st_r.cnt_sync1;
    st_nxt.cnt_prev  = st_r.cnt_sync2;
    st_nxt.cap_sync1 = ch_capture_in;
    st_nxt.cap_sync2 = st_r.cap_sync1;
    st_nxt.cap_prev  = st_r.cap_sync2;
    tick = cnt_enable && ((cnt_source == CCPT_SRC_CLOCK) || (st_r.cnt_sync2 && !st_r.cnt_prev));
    cap_edge = st_r.cap_sync2 & ~st_r.cap_prev;
    st_nxt.ovf = 1'b0;
    if (tick) begin
      st_nxt.cnt = st_r.cnt + WIDTH'(1);
      st_nxt.ovf = &st_r.cnt;
    end
    st_nxt.ev = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      case (ch_mode[i])
        CCPT_MODE_CAPTURE: begin
          st_nxt.raw[i] = 1'b0;
          if (cap_edge[i]) begin
            st_nxt.cap_buf[i] = st_r.cnt;
            st_nxt.ev[i]      = 1'b1;
          end
        end
        CCPT_MODE_COMPARE: begin
          st_nxt.raw[i] = (st_r.cnt >= ch_compare[i]);
          st_nxt.ev[i]  = (st_r.cnt == ch_compare[i]) && tick;
        end
        CCPT_MODE_PWM: begin
          st_nxt.raw[i] = (st_r.cnt < ch_compare[i]);
          st_nxt.ev[i]  = (st_r.cnt == ch_compare[i]) && tick;
        end
        default: st_nxt.raw[i] = 1'b0;
      endcase
      // dead time only in instance zero
      if (HAS_DT && dt_enable && ch_mode[i] == CCPT_MODE_PWM) begin
        if (st_nxt.raw[i] != st_r.raw[i]) begin
          st_nxt.dt_cnt[i] = dt_cycles;
          st_nxt.out_hi[i] = 1'b0;
          st_nxt.out_lo[i] = 1'b0;
        end else if (st_r.dt_cnt[i] != '0) begin
          st_nxt.dt_cnt[i] = st_r.dt_cnt[i] - CCPT_DT_WIDTH'(1);
          st_nxt.out_hi[i] = 1'b0;
          st_nxt.out_lo[i] = 1'b0;
        end else begin
          st_nxt.out_hi[i] = st_r.raw[i];
          st_nxt.out_lo[i] = !st_r.raw[i];
        end
      end else begin
        st_nxt.dt_cnt[i] = '0;
        st_nxt.out_hi[i] = st_nxt.raw[i];
        st_nxt.out_lo[i] = !st_nxt.raw[i] && (ch_mode[i] == CCPT_MODE_PWM);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r     <= '0;
      st_r.cnt <= CCPT_CNT_RST[WIDTH-1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign counter_value  = st_r.cnt;
  assign ch_capture_buf = st_r.cap_buf;
  assign ch_out         = st_r.out_hi;
  assign ch_out_comp    = st_r.out_lo;
  assign overflow_event = st_r.ovf;
  assign ch_event       = st_r.ev;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence clk_tick_s;
    cnt_enable && cnt_source == CCPT_SRC_CLOCK;
  endsequence

  sequence evt_tick_s;
    cnt_enable && cnt_source == CCPT_SRC_EVENT && st_r.cnt_sync2 && !st_r.cnt_prev;
  endsequence

  sequence dt_start_s;
    HAS_DT && dt_enable && ch_mode[1] == CCPT_MODE_PWM && st_nxt.raw[1] != st_r.raw[1];
  endsequence

  counter_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_tick_s |=> counter_value == WIDTH'($past(counter_value) + 1))
    else $error("Counter did not step by one");

  counter_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cnt_enable |=> counter_value == $past(counter_value))
    else $error("Counter moved while disabled");

  wrap_event_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_tick_s and (&counter_value)) |=> overflow_event && counter_value == '0)
    else $error("Wrap did not raise overflow event");

  capture_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ch_mode[2] == CCPT_MODE_CAPTURE && cap_edge[2]) |=> ch_capture_buf[2] == $past(counter_value))
    else $error("Capture buffer missed counter value");

  pwm_level_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ch_mode[1] == CCPT_MODE_PWM && !dt_enable && $stable(ch_mode[1]))
      |=> ch_out[1] == ($past(counter_value) < $past(ch_compare[1])))
    else $error("PWM level wrong");

  compare_level_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ch_mode[0] == CCPT_MODE_COMPARE) |=> ch_out[0] == ($past(counter_value) >= $past(ch_compare[0])))
    else $error("Compare output wrong");

  capture_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ch_mode[2] == CCPT_MODE_CAPTURE) |=> !ch_out[2])
    else $error("Capture channel drove output");

  dead_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(|(ch_out & ch_out_comp)))
    else $error("Both PWM phases active");

  event_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    evt_tick_s |=> counter_value == WIDTH'($past(counter_value) + 1))
    else $error("Event tick did not step counter");

  cmp_event_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_tick_s and (ch_mode[0] == CCPT_MODE_COMPARE && counter_value == ch_compare[0])) |=> ch_event[0])
    else $error("Compare match gave no event");

  capture_event_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ch_mode[2] == CCPT_MODE_CAPTURE && cap_edge[2]) |=> ch_event[2])
    else $error("Capture gave no event");

  dead_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    dt_start_s |=> !ch_out[1] && !ch_out_comp[1])
    else $error("Dead time did not start");

endmodule : ccpt_timer
`default_nettype wire

// ==== ccpt_src_model.sv ====
// Model of the event sources that feed the timer
`timescale 1ns/1ps
`default_nettype none
module ccpt_src_model (
  input  wire logic sys_clk,
  output logic      count_event_in,
  output logic [3:0] ch_capture_in
);
  initial begin
    count_event_in = 1'b0;
    ch_capture_in  = 4'h0;
  end
  task automatic send_event();
    @(negedge sys_clk) count_event_in = 1'b1;
    @(negedge sys_clk) count_event_in = 1'b0;
  endtask
  task automatic send_capture(input int ch);
    @(negedge sys_clk) ch_capture_in[ch] = 1'b1;
    @(negedge sys_clk) ch_capture_in[ch] = 1'b0;
  endtask
endmodule // ccpt_src_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ccpt_pkg::*;
  logic             sys_clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             en = 1'b0;
  ccpt_src_t        src = CCPT_SRC_CLOCK;
  ccpt_mode_t [3:0] mode = '{default: CCPT_MODE_OFF};
  logic [3:0][15:0] cmp = '0;
  logic             dt_en = 1'b0;
  logic [7:0]       dt_cyc = 8'h00;
  logic             ev, ovf;
  logic [3:0]       cap, out, out_c, ch_ev;
  logic [15:0]      cnt, c;
  logic [3:0][15:0] bufs;
  logic [31:0]      cnt_w;
  logic [3:0][31:0] cmp_w, bufs_w;
  logic [3:0]       out_w, out_cw;
  logic             ovf_w;
  int               n_errors = 0, compares = 0, cycles = 0, k, n_ev;
  always #2.5 sys_clk = ~sys_clk;
  ccpt_src_model ccpt_src_model_i (.sys_clk(sys_clk), .count_event_in(ev),
    .ch_capture_in(cap));
  ccpt_timer ccpt_timer_i (.sys_clk(sys_clk), .rst_b(rst_b), .cnt_enable(en),
    .cnt_source(src), .count_event_in(ev), .ch_mode(mode), .ch_compare(cmp),
    .ch_capture_in(cap), .dt_enable(dt_en), .dt_cycles(dt_cyc),
    .counter_value(cnt), .ch_capture_buf(bufs), .ch_out(out),
    .ch_out_comp(out_c), .overflow_event(ovf), .ch_event(ch_ev));
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cmp_w[i] = {16'h0000, cmp[i]};
    end
  end
  ccpt_timer #(.WIDTH(CCPT_WIDE_WIDTH), .INSTANCE(1)) ccpt_timer_wide_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .cnt_enable(en), .cnt_source(src), .count_event_in(ev), .ch_mode(mode), .ch_compare(cmp_w),
    .ch_capture_in(cap), .dt_enable(dt_en), .dt_cycles(dt_cyc),
    .counter_value(cnt_w), .ch_capture_buf(bufs_w), .ch_out(out_w),
    .ch_out_comp(out_cw), .overflow_event(ovf_w), .ch_event());
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic t_count();
    c = cnt;
    en = 1'b1;
    repeat (10) @(negedge sys_clk);
    en = 1'b0;
    check("cnt_run", c + 16'h000a, cnt);
    check("cnt_run_w", {16'h0000, c + 16'h000a}, cnt_w);
    repeat (3) @(negedge sys_clk);
    check("cnt_hold", c + 16'h000a, cnt);
  endtask
  task automatic t_event();
    src = CCPT_SRC_EVENT;
    en = 1'b1;
    c = cnt;
    repeat (3) ccpt_src_model_i.send_event();
    repeat (4) @(negedge sys_clk);
    check("ev_cnt", c + 16'h0003, cnt);
    en = 1'b0;
    ccpt_src_model_i.send_event();
    repeat (4) @(negedge sys_clk);
    check("ev_off", c + 16'h0003, cnt);
    src = CCPT_SRC_CLOCK;
  endtask
  task automatic t_capture();
    mode[2] = CCPT_MODE_CAPTURE;
    mode[3] = CCPT_MODE_COMPARE;
    ccpt_src_model_i.send_capture(3);
    ccpt_src_model_i.send_capture(2);
    k = 0;
    repeat (4) @(negedge sys_clk) k += int'(ch_ev[2] === 1'b1);
    check("cap_ev", 1, k);
    check("cap_buf", c + 16'h0003, bufs[2]);
    check("cap_buf_w", {16'h0000, c + 16'h0003}, bufs_w[2]);
    check("cap_off", 16'h0000, bufs[3]);
  endtask
  task automatic t_wrap();
    en = 1'b1;
    while (cnt !== 16'hffff) @(negedge sys_clk);
    @(negedge sys_clk);
    check("wrap_cnt", 16'h0000, cnt);
    check("wrap_ev", 1, ovf);
    check("wrap_w", 32'h0001_0000, cnt_w);
    check("ovf_w", 0, ovf_w);
    @(negedge sys_clk);
    check("ev_once", 0, ovf);
    en = 1'b0;
  endtask
  task automatic t_cmp(input logic dt);
    dt_en = dt;
    dt_cyc = 8'h02;
    mode[0] = CCPT_MODE_COMPARE;
    mode[1] = CCPT_MODE_PWM;
    cmp[0] = cnt + 16'h0005;
    cmp[1] = cnt + 16'h0005;
    en = 1'b1;
    k = 0;
    n_ev = 0;
    repeat (14) begin
      c = cnt;
      @(negedge sys_clk);
      check("ovl", 0, out[1] & out_c[1]);
      k += int'(out[1] === 1'b0 && out_c[1] === 1'b0);
      n_ev += int'(ch_ev[0] === 1'b1) + int'(ch_ev[1] === 1'b1);
      check("pwm_w", c < cmp[1], out_w[1]);
      check("pwm_nw", !out_w[1], out_cw[1]);
      if (!dt) begin
        check("cmp", c >= cmp[0], out[0]);
        check("pwm", c < cmp[1], out[1]);
        check("pwm_n", !out[1], out_c[1]);
      end
    end
    check("gap", dt ? 2 * (int'(dt_cyc) + 1) : 0, k);
    check("cmp_ev", 2, n_ev);
    en = 1'b0;
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    check("rst_cnt", 16'h0000, cnt);
    t_count();
    t_event();
    t_capture();
    t_cmp(1'b0);
    t_cmp(1'b1);
    t_wrap();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
